// ### core/ssla_alu.v
// Execution datapath for shifts, subtracts, swap, xor, widen, unlink and
// program memory table transfers, with its own status flag register.
// Assumes the decoder supplies fetched operands and holds a request
// until op_ready; program memory answers a read in the cycle of its strobe.
`timescale 1ns/1ns
`include "ssla_defs.vh"

module ssla_alu (
	input wire clock,
	input wire arst_n,
	input wire op_valid,
	input wire [3:0] op_code,
	input wire byte_mode,
	input wire [1:0] src_sel,
	input wire [15:0] operand_base,
	input wire [15:0] operand_src,
	input wire [4:0] lit5,
	input wire [9:0] lit10,
	input wire [15:0] frame_ptr,
	input wire [7:0] tbl_page,
	input wire [23:0] prog_rdata,
	output wire op_ready,
	output reg result_valid,
	output reg [15:0] result,
	output reg result_byte,
	output reg prog_rd,
	output reg prog_wr_high,
	output reg prog_wr_low,
	output reg [23:0] prog_addr,
	output reg [23:0] prog_wdata,
	output wire flag_c,
	output wire flag_dc,
	output wire flag_n,
	output wire flag_ov,
	output wire flag_z
);
	localparam ST_IDLE = 2'b01;
	localparam ST_TABLE = 2'b10;

	reg [1:0] state;
	reg [1:0] next_state;
	reg [4:0] flags;
	reg [4:0] next_flags;
	reg [15:0] next_result;
	reg next_valid;
	reg next_byte;
	reg [3:0] tbl_op;
	reg tbl_byte;
	wire take;
	wire [15:0] src_val;
	wire [15:0] sub_min;
	wire [15:0] sub_sub;
	wire sub_cin;
	wire is_rev;
	wire with_borrow;
	wire [15:0] sub_diff;
	wire sub_c;
	wire sub_dc;
	wire sub_ov;
	wire [4:0] shift_cnt;
	wire [15:0] shifted_n;
	wire [15:0] shifted_1;
	wire shift_out;
	wire [7:0] prog_hi;

	// Negative flag from the top bit of the active width
	function top_bit;
		input [15:0] value;
		input bmode;
		begin
			top_bit = bmode ? value[7] : value[15];
		end
	endfunction

	// Zero flag over the active width
	function is_zero;
		input [15:0] value;
		input bmode;
		begin
			is_zero = bmode ? (value[7:0] == 8'h00) : (value == 16'h0000);
		end
	endfunction

	assign take = op_valid & op_ready;
	assign op_ready = state[0];

	// Second operand: register, five-bit or ten-bit literal
	assign src_val = (src_sel == `SSLA_SRC_LIT5) ? {11'h000, lit5} :
		(src_sel == `SSLA_SRC_LIT10) ? {6'h00, lit10} :
		operand_src;

	// Reverse forms swap the operand order
	assign is_rev = (op_code == `SSLA_OP_REVERSE_MINUS) |
		(op_code == `SSLA_OP_REVERSE_MINUS_BORROW);
	assign with_borrow = (op_code == `SSLA_OP_MINUS_WITH_BORROW) |
		(op_code == `SSLA_OP_REVERSE_MINUS_BORROW);
	assign sub_min = is_rev ? src_val : operand_base;
	assign sub_sub = is_rev ? operand_base : src_val;
	// Carry in of 1 means no extra borrow; borrow forms use C itself
	assign sub_cin = with_borrow ? flags[`SSLA_FLAG_C] : 1'b1;

	ssla_sub_unit u_sub (
		.minuend(sub_min),
		.subtrahend(sub_sub),
		.carry_in(sub_cin),
		.byte_mode(byte_mode),
		.diff(sub_diff),
		.carry_out(sub_c),
		.digit_carry(sub_dc),
		.overflow(sub_ov)
	);

	// Counts of sixteen or more clear the word
	assign shift_cnt = (src_sel == `SSLA_SRC_LIT5) ? lit5 :
		operand_src[4:0];
	assign shifted_n = (shift_cnt >= `SSLA_SHIFT_LIMIT) ? 16'h0000 :
		(operand_base << shift_cnt[3:0]);
	assign shifted_1 = {operand_base[14:0], 1'b0};
	assign shift_out = byte_mode ? operand_base[7] : operand_base[15];
	assign prog_hi = prog_rdata[23:16];

	always @* begin
		next_state = state;
		next_flags = flags;
		next_result = result;
		next_valid = 1'b0;
		next_byte = result_byte;
		case (state)
		ST_IDLE: begin
			if (take) begin
				next_byte = byte_mode;
				next_valid = 1'b1;
				case (op_code)
				`SSLA_OP_SHIFT1: begin
					next_result = shifted_1;
					next_flags[`SSLA_FLAG_C] = shift_out;
					next_flags[`SSLA_FLAG_N] = top_bit(shifted_1, byte_mode);
					next_flags[`SSLA_FLAG_OV] = shift_out ^
						top_bit(shifted_1, byte_mode);
					next_flags[`SSLA_FLAG_Z] = is_zero(shifted_1, byte_mode);
				end
				`SSLA_OP_SHIFTN: begin
					next_byte = 1'b0;
					next_result = shifted_n;
					next_flags[`SSLA_FLAG_N] = shifted_n[15];
					next_flags[`SSLA_FLAG_Z] = (shifted_n == 16'h0000);
				end
				`SSLA_OP_SUB, `SSLA_OP_MINUS_WITH_BORROW, `SSLA_OP_REVERSE_MINUS,
				`SSLA_OP_REVERSE_MINUS_BORROW: begin
					next_result = sub_diff;
					next_flags[`SSLA_FLAG_C] = sub_c;
					next_flags[`SSLA_FLAG_DC] = sub_dc;
					next_flags[`SSLA_FLAG_N] = top_bit(sub_diff, byte_mode);
					next_flags[`SSLA_FLAG_OV] = sub_ov;
					next_flags[`SSLA_FLAG_Z] = is_zero(sub_diff, byte_mode);
				end
				`SSLA_OP_SWAP: begin
					// Byte form touches only the low byte
					if (byte_mode) begin
						next_result = {operand_base[15:8],
							operand_base[3:0], operand_base[7:4]};
					end else begin
						next_result = {operand_base[7:0],
							operand_base[15:8]};
					end
				end
				`SSLA_OP_XOR: begin
					next_result = operand_base ^ src_val;
					next_flags[`SSLA_FLAG_N] =
						top_bit(operand_base ^ src_val, byte_mode);
					next_flags[`SSLA_FLAG_Z] =
						is_zero(operand_base ^ src_val, byte_mode);
				end
				`SSLA_OP_WIDEN: begin
					next_byte = 1'b0;
					next_result = {8'h00, operand_src[7:0]};
					next_flags[`SSLA_FLAG_C] = 1'b1;
					next_flags[`SSLA_FLAG_N] = 1'b0;
					next_flags[`SSLA_FLAG_Z] =
						(operand_src[7:0] == 8'h00);
				end
				`SSLA_OP_UNLINK: begin
					// New stack pointer is the frame pointer
					next_byte = 1'b0;
					next_result = frame_ptr;
				end
				`SSLA_OP_RDH, `SSLA_OP_RDL, `SSLA_OP_WTH,
				`SSLA_OP_WTL: begin
					next_valid = 1'b0;
					next_state = ST_TABLE;
				end
				default: begin
					next_valid = 1'b0;
				end
				endcase
			end
		end
		ST_TABLE: begin
			// Second cycle: memory strobe is out, capture and finish
			next_state = ST_IDLE;
			next_valid = 1'b1;
			next_byte = tbl_byte;
			if (tbl_op == `SSLA_OP_RDH) begin
				next_result = {8'h00, prog_hi};
			end else if (tbl_op == `SSLA_OP_RDL) begin
				next_result = prog_rdata[15:0];
			end else begin
				next_valid = 1'b0;
			end
		end
		default: begin
			next_state = ST_IDLE;
		end
		endcase
	end

	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state <= ST_IDLE;
			flags <= `SSLA_FLAGS_RESET;
			result <= 16'h0000;
			result_valid <= 1'b0;
			result_byte <= 1'b0;
			tbl_op <= `SSLA_OP_SHIFT1;
			tbl_byte <= 1'b0;
		end else begin
			state <= next_state;
			flags <= next_flags;
			result <= next_result;
			result_valid <= next_valid;
			result_byte <= next_byte;
			if (take) begin
				tbl_op <= op_code;
				tbl_byte <= (op_code == `SSLA_OP_RDH) | byte_mode;
			end
		end
	end

	// Program memory strobes stand for the second cycle of a table op
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			prog_rd <= 1'b0;
			prog_wr_high <= 1'b0;
			prog_wr_low <= 1'b0;
			prog_addr <= 24'h000000;
			prog_wdata <= 24'h000000;
		end else begin
			prog_rd <= 1'b0;
			prog_wr_high <= 1'b0;
			prog_wr_low <= 1'b0;
			if (take) begin
				prog_addr <= {tbl_page, operand_base};
				prog_rd <= (op_code == `SSLA_OP_RDH) |
					(op_code == `SSLA_OP_RDL);
				prog_wr_high <= (op_code == `SSLA_OP_WTH);
				prog_wr_low <= (op_code == `SSLA_OP_WTL);
				if (op_code == `SSLA_OP_WTH) begin
					prog_wdata <= {operand_src[7:0], 16'h0000};
				end else begin
					prog_wdata <= {8'h00, operand_src};
				end
			end
		end
	end

	assign flag_c = flags[`SSLA_FLAG_C];
	assign flag_dc = flags[`SSLA_FLAG_DC];
	assign flag_n = flags[`SSLA_FLAG_N];
	assign flag_ov = flags[`SSLA_FLAG_OV];
	assign flag_z = flags[`SSLA_FLAG_Z];
endmodule // ssla_alu

// ### core/ssla_defs.vh
// Constants for the shift, subtract, logic and table transfer datapath.
// Assumes an instruction decoder that presents one operation per request.
// Contract
// - A one-bit left shift of any operand finishes in one cycle and updates C, N, OV and Z.
// - A left shift by a register count writes the destination in one cycle and updates only N and Z.
// - A left shift by an immediate takes its count from the five-bit literal and updates only N and Z.
// - Subtract with borrow also subtracts the inverted carry and updates C, DC, N, OV and Z.
// - The immediate borrow subtract takes the ten-bit literal and the inverted carry from the named register and writes it back.
// - The reverse borrow subtract takes the base operand and the inverted carry from the five-bit literal.
// - The reverse borrow subtract on a file register stores the working value minus the file value minus the inverted carry.
// - The high table read copies program bits 23 to 16 into the destination low byte and takes two cycles.
// - The low table read copies program bits 15 to 0 into the destination and changes no flag.
// - The high table write places the source low byte into program bits 23 to 16 and takes two cycles.
// - The low table write places the whole source word into program bits 15 to 0 and leaves the flags alone.
// - Zero extension widens the source low byte with zeros in one cycle and updates C, Z and N.
`ifndef SSLA_DEFS_VH
`define SSLA_DEFS_VH

`define SSLA_OP_W 4
`define SSLA_OP_SHIFT1 4'h0
`define SSLA_OP_SHIFTN 4'h1
`define SSLA_OP_SUB 4'h2
`define SSLA_OP_MINUS_WITH_BORROW 4'h3
`define SSLA_OP_REVERSE_MINUS 4'h4
`define SSLA_OP_REVERSE_MINUS_BORROW 4'h5
`define SSLA_OP_SWAP 4'h6
`define SSLA_OP_XOR 4'h7
`define SSLA_OP_WIDEN 4'h8
`define SSLA_OP_UNLINK 4'h9
`define SSLA_OP_RDH 4'ha
`define SSLA_OP_RDL 4'hb
`define SSLA_OP_WTH 4'hc
`define SSLA_OP_WTL 4'hd

`define SSLA_SRC_REG 2'h0
`define SSLA_SRC_LIT5 2'h1
`define SSLA_SRC_LIT10 2'h2

`define SSLA_FLAG_C 0
`define SSLA_FLAG_DC 1
`define SSLA_FLAG_N 2
`define SSLA_FLAG_OV 3
`define SSLA_FLAG_Z 4
`define SSLA_FLAGS_RESET 5'h00

`define SSLA_TBL_CYCLES 2
`define SSLA_SHIFT_LIMIT 5'h10

`endif

// ### core/ssla_sub_unit.v
// Subtractor with borrow input, carry, digit carry and overflow outputs.
// Operands arrive already ordered; byte mode looks at the low byte only.
`timescale 1ns/1ns
`include "ssla_defs.vh"

module ssla_sub_unit (
	input wire [15:0] minuend,
	input wire [15:0] subtrahend,
	input wire carry_in,
	input wire byte_mode,
	output wire [15:0] diff,
	output wire carry_out,
	output wire digit_carry,
	output wire overflow
);
	wire [16:0] full;
	wire [4:0] low_nib;
	wire [8:0] low_byte;
	wire [15:0] inv;

	assign inv = ~subtrahend;
	// Two's complement: a + ~b + carry, carry is the no-borrow sense
	assign full = {1'b0, minuend} + {1'b0, inv} + {16'h0000, carry_in};
	assign low_nib = {1'b0, minuend[3:0]} + {1'b0, inv[3:0]}
		+ {4'h0, carry_in};
	assign low_byte = {1'b0, minuend[7:0]} + {1'b0, inv[7:0]}
		+ {8'h00, carry_in};
	assign diff = full[15:0];
	assign carry_out = byte_mode ? low_byte[8] : full[16];
	// Digit carry comes from bit 3 in byte mode and bit 7 in word mode
	assign digit_carry = byte_mode ? low_nib[4] : low_byte[8];
	assign overflow = byte_mode ?
		((minuend[7] ^ subtrahend[7]) & (minuend[7] ^ low_byte[7])) :
		((minuend[15] ^ subtrahend[15]) & (minuend[15] ^ full[15]));
endmodule // ssla_sub_unit

// ### testbench/ssla_prog_mem.sv
// Program memory partner: sixteen 24-bit words, addressed by the low bits.
// Answers a read in the cycle of the strobe; the bus wanders otherwise.
`timescale 1ns/1ns

module ssla_prog_mem (
	input wire logic clock,
	input wire logic prog_rd,
	input wire logic prog_wr_high,
	input wire logic prog_wr_low,
	input wire logic [23:0] prog_addr,
	input wire logic [23:0] prog_wdata,
	output logic [23:0] prog_rdata
);
	logic [23:0] mem [0:15];
	logic [23:0] junk = 24'h5a5a5a;
	initial begin
		for (int i = 0; i < 16; i++)
			mem[i] = 24'h000000;
	end
	// Released bus toggles so a late sample cannot pass by chance
	always @(posedge clock) begin
		junk <= ~junk;
		if (prog_wr_high)
			mem[prog_addr[3:0]][23:16] <= prog_wdata[23:16];
		if (prog_wr_low)
			mem[prog_addr[3:0]][15:0] <= prog_wdata[15:0];
	end
	assign prog_rdata = prog_rd ? mem[prog_addr[3:0]] : junk;
endmodule // ssla_prog_mem

// ### testbench/ssla_alu_checker.sv
// Timing and result checks on the datapath ports.
// Bound into every ssla_alu instance; sees only its ports.
`timescale 1ns/1ns
`include "ssla_defs.vh"

module ssla_alu_checker (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic op_valid,
	input wire logic [3:0] op_code,
	input wire logic byte_mode,
	input wire logic [1:0] src_sel,
	input wire logic [15:0] operand_base,
	input wire logic [15:0] operand_src,
	input wire logic [23:0] prog_rdata,
	input wire logic op_ready,
	input wire logic result_valid,
	input wire logic [15:0] result,
	input wire logic result_byte,
	input wire logic prog_rd,
	input wire logic prog_wr_high,
	input wire logic prog_wr_low,
	input wire logic [23:0] prog_wdata,
	input wire logic flag_c,
	input wire logic flag_dc,
	input wire logic flag_n,
	input wire logic flag_ov,
	input wire logic flag_z
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);
	wire tk = op_valid & op_ready;
	wire [4:0] fl = {flag_z, flag_ov, flag_n, flag_dc, flag_c};
	wire [2:0] kept = {flag_c, flag_dc, flag_ov};
	property p_minus_with_borrow;
		tk && op_code == `SSLA_OP_MINUS_WITH_BORROW && src_sel == 2'h0 && !byte_mode |=>
		result == $past(operand_base) - $past(operand_src)
			- {15'h0000, ~$past(flag_c)};
	endproperty
	a_minus_with_borrow: assert property (p_minus_with_borrow) else $error("minus_with_borrow result");
	property p_sl1;
		tk && op_code == `SSLA_OP_SHIFT1 && !byte_mode &&
		operand_base == operand_src |=> result_valid && !result[0] &&
		flag_c == $past(operand_src[15]) && flag_ov == (flag_c ^ flag_n);
	endproperty
	a_sl1: assert property (p_sl1) else $error("shift one");
	property p_sln;
		tk && op_code == `SSLA_OP_SHIFTN |=> result_valid && kept == $past(kept);
	endproperty
	a_sln: assert property (p_sln) else $error("shift n flags");
	property p_rdh;
		tk && op_code == `SSLA_OP_RDH |=> prog_rd && !op_ready ##1 result_valid
		&& result_byte && result == {8'h00, $past(prog_rdata[23:16])};
	endproperty
	a_rdh: assert property (p_rdh) else $error("read high");
	property p_rdl;
		tk && op_code == `SSLA_OP_RDL |=> prog_rd ##1
		result == $past(prog_rdata[15:0]) && fl == $past(fl, 2);
	endproperty
	a_rdl: assert property (p_rdl) else $error("read low");
	property p_wth;
		tk && op_code == `SSLA_OP_WTH |=> prog_wr_high && !op_ready &&
		prog_wdata[23:16] == $past(operand_src[7:0]) ##1 !result_valid;
	endproperty
	a_wth: assert property (p_wth) else $error("write high");
	property p_wtl;
		tk && op_code == `SSLA_OP_WTL |=> prog_wr_low &&
		prog_wdata[15:0] == $past(operand_src) && fl == $past(fl);
	endproperty
	a_wtl: assert property (p_wtl) else $error("write low");
	property p_widen;
		tk && op_code == `SSLA_OP_WIDEN |=> flag_c && !flag_n &&
		result == {8'h00, $past(operand_src[7:0])};
	endproperty
	a_widen: assert property (p_widen) else $error("widen");
endmodule // ssla_alu_checker

bind ssla_alu ssla_alu_checker u_chk (.clock(clock), .arst_n(arst_n),
	.op_valid(op_valid), .op_code(op_code), .byte_mode(byte_mode),
	.src_sel(src_sel), .operand_base(operand_base),
	.operand_src(operand_src), .prog_rdata(prog_rdata),
	.op_ready(op_ready), .result_valid(result_valid), .result(result),
	.result_byte(result_byte), .prog_rd(prog_rd),
	.prog_wr_high(prog_wr_high), .prog_wr_low(prog_wr_low),
	.prog_wdata(prog_wdata), .flag_c(flag_c), .flag_dc(flag_dc),
	.flag_n(flag_n), .flag_ov(flag_ov), .flag_z(flag_z));

// ### testbench/test_shift_subtract_logic_table_alu.sv
// Self-checking bench for the datapath, one task per scenario.
// Program memory partner on the far side; inputs change at falling edges.
`timescale 1ns/1ns
`include "ssla_defs.vh"

module test_shift_subtract_logic_table_alu;
	logic clock = 0, arst_n = 0, op_valid = 0, byte_mode = 0;
	logic [3:0] op_code = 4'h0;
	logic [1:0] src_sel = 2'h0;
	logic [15:0] operand_base = 16'h0000, operand_src = 16'h0000, result;
	logic [4:0] lit5 = 5'h00, was;
	logic [9:0] lit10 = 10'h000;
	logic [15:0] fp = 16'h0000;
	logic [23:0] prog_rdata, prog_addr, prog_wdata;
	logic op_ready, result_valid, result_byte, prog_rd, prog_wr_high;
	logic prog_wr_low, flag_c, flag_dc, flag_n, flag_ov, flag_z;
	wire [4:0] fl = {flag_z, flag_ov, flag_n, flag_dc, flag_c};
	int fail_count = 0, compares = 0;
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
	fail_count++; $display("Error %s expected %h seen %h", nm, ex, got); end end
	always #20 clock = ~clock;
	ssla_alu dut (.clock(clock), .arst_n(arst_n), .op_valid(op_valid),
		.op_code(op_code), .byte_mode(byte_mode), .src_sel(src_sel),
		.operand_base(operand_base), .operand_src(operand_src), .lit5(lit5),
		.lit10(lit10), .frame_ptr(fp), .tbl_page(8'h01),
		.prog_rdata(prog_rdata), .op_ready(op_ready),
		.result_valid(result_valid), .result(result),
		.result_byte(result_byte), .prog_rd(prog_rd),
		.prog_wr_high(prog_wr_high), .prog_wr_low(prog_wr_low),
		.prog_addr(prog_addr), .prog_wdata(prog_wdata), .flag_c(flag_c),
		.flag_dc(flag_dc), .flag_n(flag_n), .flag_ov(flag_ov),
		.flag_z(flag_z));
	ssla_prog_mem mem (.clock(clock), .prog_rd(prog_rd),
		.prog_wr_high(prog_wr_high), .prog_wr_low(prog_wr_low),
		.prog_addr(prog_addr), .prog_wdata(prog_wdata),
		.prog_rdata(prog_rdata));
	// Request held until taken; returns in the cycle after the take
	task go(input [3:0] op, input bm, input [1:0] sel, input [15:0] b, s);
		@(negedge clock);
		was = fl;
		op_valid = 1'b1;
		op_code = op;
		byte_mode = bm;
		src_sel = sel;
		operand_base = b;
		operand_src = s;
		while (op_ready !== 1'b1) @(negedge clock);
		@(negedge clock);
		op_valid = 1'b0;
	endtask
	task t_shift;
		go(`SSLA_OP_SHIFT1, 1'b0, 2'h0, 16'h8001, 16'h8001);
		`CHK("sl1", 16'h0002, result)
		`CHK("sl1 flags", 5'h09, fl)
		go(`SSLA_OP_SHIFTN, 1'b0, 2'h0, 16'h0003, 16'h0004);
		`CHK("sln", 16'h0030, result)
		`CHK("sln flags", {1'b0, was[3], 1'b0, was[1:0]}, fl)
		lit5 = 5'h0f;
		go(`SSLA_OP_SHIFTN, 1'b0, 2'h1, 16'h0003, 16'h0000);
		`CHK("sl lit", 16'h8000, result)
		`CHK("sl lit flags", {1'b0, was[3], 1'b1, was[1:0]}, fl)
	endtask
	task t_sub;
		go(`SSLA_OP_SUB, 1'b0, 2'h0, 16'h0000, 16'h0001);
		go(`SSLA_OP_MINUS_WITH_BORROW, 1'b0, 2'h0, 16'h0010, 16'h0001);
		`CHK("minus_with_borrow", 16'h000e, result)
		`CHK("minus_with_borrow flags", 5'h03, fl)
		lit10 = 10'h3ff;
		go(`SSLA_OP_MINUS_WITH_BORROW, 1'b0, 2'h2, 16'h1000, 16'h0000);
		`CHK("minus_with_borrow lit", 16'h0c01, result)
		lit5 = 5'h1f;
		go(`SSLA_OP_REVERSE_MINUS_BORROW, 1'b0, 2'h1, 16'h0020, 16'h0000);
		`CHK("reverse_minus_borrow lit", 16'hffff, result)
		`CHK("reverse_minus_borrow flags", 5'h04, fl)
		go(`SSLA_OP_REVERSE_MINUS_BORROW, 1'b0, 2'h0, 16'h0003, 16'h0005);
		`CHK("reverse_minus_borrow reg", 16'h0001, result)
	endtask
	task t_misc;
		go(`SSLA_OP_WIDEN, 1'b0, 2'h0, 16'hff80, 16'hff80);
		`CHK("widen", 16'h0080, result)
		`CHK("widen flags", 3'b001, {fl[4], fl[2], fl[0]})
		go(`SSLA_OP_SWAP, 1'b1, 2'h0, 16'h12a5, 16'h12a5);
		`CHK("swap b", 8'h5a, result[7:0])
		go(`SSLA_OP_SWAP, 1'b0, 2'h0, 16'h12a5, 16'h12a5);
		`CHK("swap w", 16'ha512, result)
		`CHK("swap flags", was, fl)
		go(`SSLA_OP_XOR, 1'b0, 2'h0, 16'h00ff, 16'h00ff);
		`CHK("xor", 16'h0000, result)
		`CHK("xor flags", {1'b1, was[3], 1'b0, was[1:0]}, fl)
		fp = 16'h1234;
		go(`SSLA_OP_UNLINK, 1'b0, 2'h0, 16'h0000, 16'h0000);
		`CHK("unlink", 16'h1234, result)
		`CHK("unlink flags", was, fl)
		`CHK("unlink byte", 1'b0, result_byte)
	endtask
	task t_table;
		go(`SSLA_OP_WTH, 1'b0, 2'h0, 16'h0003, 16'h00c3);
		@(negedge clock);
		go(`SSLA_OP_WTL, 1'b0, 2'h0, 16'h0003, 16'hbeef);
		@(negedge clock);
		go(`SSLA_OP_RDL, 1'b0, 2'h0, 16'h0003, 16'h0000);
		@(negedge clock);
		`CHK("rdl", 16'hbeef, result)
		`CHK("rdl flags", was, fl)
		go(`SSLA_OP_RDH, 1'b0, 2'h0, 16'h0003, 16'h0000);
		@(negedge clock);
		`CHK("rdh", 16'h00c3, result)
		`CHK("rdh valid", 1'b1, result_valid)
	endtask
	task close_out;
		$display("Comparisons %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clock);
		@(negedge clock);
		arst_n = 1'b1;
		t_shift;
		t_sub;
		t_misc;
		t_table;
		close_out;
	end
	initial begin
		#40000;
		fail_count++;
		close_out;
	end
endmodule // test_shift_subtract_logic_table_alu
